// >>> hw/tsl_ee_mem.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_ee_mem (
  input wire logic clk, // System clock, write and system read port.
  input wire logic we, // Write strobe.
  input wire logic [4:0] waddr, // Write word address.
  input wire logic [31:0] wdata, // Write word.
  input wire logic [4:0] raddr_sys, // System read address.
  output logic [31:0] rdata_sys, // System read word, registered.
  input wire logic sclk, // Serial clock, serial read port.
  input wire logic [4:0] raddr_link, // Serial read address.
  output logic [31:0] rdata_link // Serial read word, registered on rising SCLK.
);
  logic [31:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_sys <= mem[raddr_sys];
  end

  // Read on the serial clock so a word is ready one rising edge after its address.
  always_ff @(posedge sclk) begin
    rdata_link <= mem[raddr_link];
  end
endmodule
`default_nettype wire

// >>> hw/tsl_spi_port.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_spi_port
  import tsl_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic sclk, // Serial clock from the master.
  input wire logic ss_n, // Serial select, active low.
  input wire logic mosi, // Serial data in.
  output logic miso_o, // Serial data out.
  output logic miso_oe, // Serial data out enable.
  output logic miso_pd_en, // Pull-down switch on the serial data out.
  output logic irq, // Attention request to the master.
  input wire logic irq_req, // Attention request from the tag logic.
  input wire logic serial_side_supply, // High when running from the serial-side supply only.
  output logic fifo_push, // One-cycle FIFO load strobe.
  output logic [7:0] fifo_wdata, // FIFO load byte.
  output logic fifo_pop, // One-cycle FIFO consume strobe.
  input wire logic [7:0] fifo_head, // Oldest FIFO byte.
  output logic cmd_valid, // One-cycle direct command strobe.
  output logic [5:0] cmd_code, // Direct command code.
  input wire logic rf_wr_req, // Contactless word write request, held until ack.
  input wire logic [6:0] rf_wr_addr, // Contactless write word address.
  input wire logic [31:0] rf_wr_data, // Contactless write word.
  output logic rf_wr_ack, // One-cycle write acknowledge.
  output logic rf_wr_denied, // With ack: write was rejected.
  input wire logic rf_rd_req, // Contactless word read strobe.
  input wire logic [6:0] rf_rd_addr, // Contactless read word address.
  output logic rf_rd_valid, // One-cycle read answer strobe.
  output logic [31:0] rf_rd_data, // Contactless read word.
  output logic rf_rd_denied, // With valid: read was refused.
  output logic [31:0] cfg_word, // Configuration word.
  output logic powerup_event_enable, // Configuration power-up event enable.
  output logic active_entry_event_enable // Configuration active-entry event enable.
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic link_rst;
  logic spi_rst;
  tsl_state_t state;
  tsl_state_t next_state;
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic [4:0] reg_addr;
  logic [1:0] ee_byte;
  logic [6:0] ee_rd_addr;
  logic [6:0] ee_wr_addr;
  logic [31:0] ee_wr_data;
  logic [31:0] tx_sh;
  logic ev_tgl;
  tsl_ev_t ev_kind;
  logic [4:0] ev_addr;
  logic [7:0] ev_data;
  logic [31:0] mem_q_link;
  logic [31:0] mem_q_sys;
  logic [31:0] wlock;
  logic [31:0] rlock;
  logic [1:0] io_cfg;
  logic [5:0] last_cmd;
  logic ee_pend;
  logic ee_done;
  logic ee_err;
  logic ev_s;
  logic ev_q;
  logic ss_s;
  logic ss_q;
  logic supply_s;
  logic rd_pend;
  logic [6:0] rd_addr_q;

  // ------------------------------------------------------------
  // Link side decode
  // ------------------------------------------------------------
  wire [7:0] rx_byte = {rx_sh, mosi};
  wire byte_done = bit_cnt == BIT_LAST;
  wire [2:0] mode_code = rx_byte[7:5];
  wire [4:0] trailer = rx_byte[4:0];
  wire in_mode = state == S_MODE;
  wire ev_regw = (state == S_REG_WR) && byte_done;
  wire ev_fifow = (state == S_FIFO_WR) && byte_done;
  wire ev_pop = (state == S_FIFO_RD) && (bit_cnt == 3'h0);
  wire ev_cmd = in_mode && byte_done && (rx_byte[7:6] == MODE_CMD);
  wire ev_arm = (state == S_EEW_DATA) && byte_done && (ee_byte == EE_LAST_BYTE);
  wire ev_go = ev_regw | ev_fifow | ev_pop | ev_cmd | ev_arm;
  wire tsl_ev_t next_ev_kind = ev_regw ? EV_REG_WR : ev_fifow ? EV_FIFO_WR : ev_pop ? EV_FIFO_POP :
                               ev_cmd ? EV_CMD : EV_EE_ARM;
  wire rd_state = (state == S_REG_RD) || (state == S_EER_DATA) || (state == S_FIFO_RD);
  wire tx_load = rd_state && (bit_cnt == 3'h0) && ((state != S_EER_DATA) || (ee_byte == 2'h0));
  wire [7:0] reg_q = (reg_addr == REG_IO_CFG) ? {6'h00, io_cfg} :
                     (reg_addr == REG_EE_STATUS) ? {4'h0, supply_s, ee_pend, ee_err, ee_done} :
                     (reg_addr == REG_LAST_CMD) ? {2'h0, last_cmd} : 8'h00; // R21
  wire [31:0] tx_word = tsl_word_view(ee_rd_addr, mem_q_link, cfg_word, wlock, rlock);
  wire [31:0] tx_val = (state == S_REG_RD) ? {reg_q, 24'h000000} :
                       (state == S_FIFO_RD) ? {fifo_head, 24'h000000} : tx_word;

  always_comb begin
    next_state = state;
    unique case (state)
      S_MODE: begin
        if (byte_done) begin // R04
          if (mode_code == MODE_REG_WR) begin
            next_state = S_REG_WR; // R05
          end else if (mode_code == MODE_REG_RD) begin
            next_state = S_REG_RD; // R05
          end else if (mode_code == MODE_EE_WR && trailer == TRAIL_ZERO) begin
            next_state = S_EEW_ADDR; // R07
          end else if (mode_code == MODE_EE_RD && trailer == TRAIL_ONES) begin
            next_state = S_EER_ADDR; // R07
          end else if (mode_code == MODE_FIFO_WR && trailer == TRAIL_ZERO) begin
            next_state = S_FIFO_WR; // R08
          end else if (mode_code == MODE_FIFO_RD && trailer == TRAIL_ONES) begin
            next_state = S_FIFO_RD; // R08
          end else begin
            next_state = S_DISCARD; // R09
          end
        end
      end
      S_EEW_ADDR: next_state = byte_done ? S_EEW_DATA : S_EEW_ADDR;
      S_EEW_DATA: next_state = ev_arm ? S_DISCARD : S_EEW_DATA;
      S_EER_ADDR: next_state = byte_done ? S_EER_DATA : S_EER_ADDR;
      S_REG_WR, S_REG_RD, S_EER_DATA, S_FIFO_WR, S_FIFO_RD, S_DISCARD: next_state = state;
      default: next_state = S_DISCARD;
    endcase
  end

  // ------------------------------------------------------------
  // Link side, falling SCLK edge
  // ------------------------------------------------------------
  // Select high holds the mode decoder, counters, shifters and MISO enable in reset, so each frame starts at a mode byte.
  assign spi_rst = ss_n | link_rst; // R01 R24

  always_ff @(negedge sclk or posedge spi_rst) begin
    if (spi_rst) begin
      state <= S_MODE; // R24
      bit_cnt <= 3'h0; // R24
      rx_sh <= 7'h00;
      reg_addr <= 5'h00;
      ee_byte <= 2'h0;
      ee_rd_addr <= 7'h00;
    end else begin
      state <= next_state;
      bit_cnt <= bit_cnt + 3'h1; // R03
      rx_sh <= rx_byte[6:0]; // R02 R03
      if (in_mode && byte_done) begin
        reg_addr <= trailer; // R05
      end else if ((state == S_REG_WR || state == S_REG_RD) && byte_done) begin
        reg_addr <= reg_addr + 5'h01; // R06
      end
      if ((state == S_EEW_DATA || state == S_EER_DATA) && byte_done) begin
        ee_byte <= ee_byte + 2'h1;
      end
      // Prefetch: the word address is known after seven bits, one rising edge before it is needed.
      if (state == S_EER_ADDR && bit_cnt == 3'h6) begin
        ee_rd_addr <= rx_byte[6:0]; // R22
      end else if (state == S_EER_DATA && bit_cnt == 3'h0 && ee_byte == 2'h0) begin
        ee_rd_addr <= ee_rd_addr + 7'h01; // R07
      end
    end
  end

  // Held across the select rise so the system side can still read them.
  always_ff @(negedge sclk) begin
    if (ev_go) begin
      ev_kind <= next_ev_kind;
      ev_addr <= reg_addr;
      ev_data <= rx_byte;
    end
    if (state == S_EEW_ADDR && byte_done) begin
      ee_wr_addr <= rx_byte[7:1]; // R22
    end
    if (state == S_EEW_DATA && byte_done) begin
      ee_wr_data <= {ee_wr_data[23:0], rx_byte}; // R03
    end
  end

  always_ff @(negedge sclk or posedge link_rst) begin
    if (link_rst) begin
      ev_tgl <= 1'b0;
    end else if (ev_go) begin
      ev_tgl <= ~ev_tgl; // R20 R23 R25
    end
  end

  // ------------------------------------------------------------
  // Link side, rising SCLK edge
  // ------------------------------------------------------------
  always_ff @(posedge sclk or posedge spi_rst) begin
    if (spi_rst) begin
      tx_sh <= 32'h0000_0000;
      miso_oe <= 1'b0; // R10
    end else if (tx_load) begin
      tx_sh <= tx_val; // R21
      miso_oe <= 1'b1; // R10
    end else begin
      tx_sh <= {tx_sh[30:0], 1'b0}; // R03 R21
    end
  end

  assign miso_o = tx_sh[31];
  assign miso_pd_en = ~miso_oe & io_cfg[IO_PD_A_BIT] & io_cfg[IO_PD_B_BIT]; // R11

  // ------------------------------------------------------------
  // Crossings into the system clock
  // ------------------------------------------------------------
  tsl_sync #(.RESET_VAL(1'b0)) u_sync_ev (
    .clk(clk),
    .rst_n(rst_n),
    .d(ev_tgl),
    .q(ev_s)
  );

  tsl_sync #(.RESET_VAL(1'b1)) u_sync_ss (
    .clk(clk),
    .rst_n(rst_n),
    .d(ss_n),
    .q(ss_s)
  );

  tsl_sync #(.RESET_VAL(1'b0)) u_sync_supply (
    .clk(clk),
    .rst_n(rst_n),
    .d(serial_side_supply),
    .q(supply_s)
  );

  // ------------------------------------------------------------
  // System side decode
  // ------------------------------------------------------------
  wire ev_hit = ev_s ^ ev_q;
  wire ss_rise = ss_s & ~ss_q;
  wire full_power = ~supply_s;
  wire spi_commit = ss_rise & ee_pend;
  wire rf_commit = rf_wr_req & ~spi_commit;
  wire [6:0] wr_addr = spi_commit ? ee_wr_addr : rf_wr_addr;
  wire [31:0] wr_data = spi_commit ? ee_wr_data : rf_wr_data;
  wire commit = spi_commit | rf_commit;
  // Word 0 and 1 are never writable, which makes lock bit 0 meaningless.
  wire wr_ok = (wr_addr <= EE_LAST_WORD) && (wr_addr > EE_WORD_FAB) && !wlock[wr_addr[4:0]] &&
               !((wr_addr == EE_WORD_WLOCK) && wlock[WLOCK_SELF_BIT]); // R16 R17
  wire do_write = commit & wr_ok;
  wire mem_we = do_write && (wr_addr > EE_WORD_RLOCK);
  wire rd_deny = (rd_addr_q > EE_LAST_WORD) || ((rd_addr_q > EE_WORD_RLOCK) && rlock[rd_addr_q[4:0]]); // R18 R19

  tsl_ee_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(wr_addr[4:0]),
    .wdata(wr_data),
    .raddr_sys(rf_rd_addr[4:0]),
    .rdata_sys(mem_q_sys),
    .sclk(sclk),
    .raddr_link(ee_rd_addr[4:0]),
    .rdata_link(mem_q_link)
  );

  // ------------------------------------------------------------
  // System side registers
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    link_rst <= ~rst_n;
    if (!rst_n) begin
      ev_q <= 1'b0;
      ss_q <= 1'b1;
      io_cfg <= IO_CFG_RESET;
      last_cmd <= 6'h00;
      cfg_word <= CFG_WORD_RESET;
      wlock <= LOCK_RESET;
      rlock <= LOCK_RESET;
      ee_pend <= 1'b0;
      ee_done <= 1'b0;
      ee_err <= 1'b0;
      fifo_push <= 1'b0;
      fifo_wdata <= 8'h00;
      fifo_pop <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 6'h00;
      rf_wr_ack <= 1'b0;
      rf_wr_denied <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr_q <= 7'h00;
      rf_rd_valid <= 1'b0;
      rf_rd_data <= 32'h0000_0000;
      rf_rd_denied <= 1'b0;
      irq <= 1'b0;
    end else begin
      ev_q <= ev_s;
      ss_q <= ss_s;
      irq <= irq_req; // R12
      fifo_push <= ev_hit && ev_kind == EV_FIFO_WR && full_power; // R08 R13
      fifo_pop <= ev_hit && ev_kind == EV_FIFO_POP && full_power; // R25 R13
      cmd_valid <= ev_hit && ev_kind == EV_CMD && full_power; // R23 R13
      if (ev_hit && ev_kind == EV_FIFO_WR) begin
        fifo_wdata <= ev_data;
      end
      if (ev_hit && ev_kind == EV_CMD && full_power) begin
        cmd_code <= ev_data[5:0]; // R09
        last_cmd <= ev_data[5:0];
      end
      if (ev_hit && ev_kind == EV_REG_WR && ev_addr == REG_IO_CFG) begin
        io_cfg <= ev_data[1:0]; // R20
      end
      if (ev_hit && ev_kind == EV_EE_ARM) begin
        ee_pend <= 1'b1; // R07
        ee_done <= 1'b0;
        ee_err <= 1'b0;
      end else if (spi_commit) begin
        ee_pend <= 1'b0;
        ee_done <= 1'b1;
        ee_err <= ~wr_ok; // R16
      end else if (ss_s && !ss_q) begin
        ee_pend <= 1'b0;
      end
      if (do_write && wr_addr == EE_WORD_CFG) begin
        cfg_word <= wr_data;
      end
      if (do_write && wr_addr == EE_WORD_WLOCK) begin
        wlock <= wlock | wr_data; // R15
      end
      if (do_write && wr_addr == EE_WORD_RLOCK) begin
        rlock <= rlock | wr_data; // R15
      end
      rf_wr_ack <= rf_commit;
      rf_wr_denied <= rf_commit & ~wr_ok; // R16
      rd_pend <= rf_rd_req;
      if (rf_rd_req) begin
        rd_addr_q <= rf_rd_addr;
      end
      rf_rd_valid <= rd_pend;
      if (rd_pend) begin
        rf_rd_denied <= rd_deny; // R18
        rf_rd_data <= rd_deny ? 32'h0000_0000 : tsl_word_view(rd_addr_q, mem_q_sys, cfg_word, wlock, rlock);
      end
    end
  end

  assign powerup_event_enable = cfg_word[CFG_PU_BIT];
  assign active_entry_event_enable = cfg_word[CFG_L4_BIT];
endmodule
`default_nettype wire

// >>> hw/tsl_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic d, // Asynchronous level.
  output logic q // Synchronised level.
);
  logic meta;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> inc/tsl_pkg.sv
// Notes on behaviour
// (R01) Serial port held in reset while select is high, enabled only while low.
// (R02) MOSI is sampled on the falling edge of SCLK.
// (R03) Transfers are 8-bit bytes, most significant bit first.
// (R04) Top three bits of the first byte pick the mode; five bits follow.
// (R05) Mode 000 writes and 001 reads registers at the five-bit address.
// (R06) Further register data bytes use the previous address plus one.
// (R07) 010/zeros writes one EEPROM word; 011/ones reads words with auto-increment.
// (R08) 100/zeros loads FIFO bytes; 101/ones returns successive FIFO bytes.
// (R09) Top bits 11 make the low six bits a direct command code.
// (R10) MISO is released except while read data is being driven.
// (R11) Released MISO gets the pull-down when both option bits are set.
// (R12) Device is slave only and asks for attention on its interrupt pin.
// (R13) On serial-side supply only register and EEPROM access is honoured.
// (R14) Master should keep select high while the port is unused.
// (R15) Lock word bits once set stay set; clearing has no effect.
// (R16) A set write-lock bit rejects writes to that word from either side.
// (R17) Write-lock bit 0 is ignored; bit 2 freezes the write-lock word.
// (R18) A set read-lock bit blocks contactless reads but not serial reads.
// (R19) Read-lock bits of words 0 to 4 are ignored.
// (R20) Register bytes commit on their eighth falling edge; partial bytes dropped.
// (R21) Read bits change on rising SCLK; absent registers read as zero.
// (R22) Word address is the upper seven bits; valid words 00h to 1Fh.
// (R23) Direct command executes on the last falling edge of its byte.
// (R24) Select falling clears bit counter and mode decoder.
// (R25) A FIFO byte counts as read once its first bit is clocked out.
package tsl_pkg;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] MODE_REG_WR = 3'h0;
  localparam logic [2:0] MODE_REG_RD = 3'h1;
  localparam logic [2:0] MODE_EE_WR = 3'h2;
  localparam logic [2:0] MODE_EE_RD = 3'h3;
  localparam logic [2:0] MODE_FIFO_WR = 3'h4;
  localparam logic [2:0] MODE_FIFO_RD = 3'h5;
  localparam logic [1:0] MODE_CMD = 2'h3;
  localparam logic [4:0] TRAIL_ZERO = 5'h00;
  localparam logic [4:0] TRAIL_ONES = 5'h1f;
  localparam logic [1:0] EE_LAST_BYTE = 2'h3;
  localparam logic [6:0] EE_LAST_WORD = 7'h1f;
  localparam logic [6:0] EE_WORD_FAB = 7'h01;
  localparam logic [6:0] EE_WORD_CFG = 7'h02;
  localparam logic [6:0] EE_WORD_WLOCK = 7'h03;
  localparam logic [6:0] EE_WORD_RLOCK = 7'h04;
  localparam int WLOCK_SELF_BIT = 2;
  localparam logic [31:0] CFG_WORD_RESET = 32'h2600_0000;
  localparam logic [31:0] LOCK_RESET = 32'h0000_0000;
  localparam int CFG_PU_BIT = 14;
  localparam int CFG_L4_BIT = 13;
  localparam logic [4:0] REG_IO_CFG = 5'h00;
  localparam logic [4:0] REG_EE_STATUS = 5'h01;
  localparam logic [4:0] REG_LAST_CMD = 5'h02;
  localparam logic [1:0] IO_CFG_RESET = 2'h0;
  localparam int IO_PD_A_BIT = 0;
  localparam int IO_PD_B_BIT = 1;

  typedef enum logic [2:0] {
    EV_REG_WR = 3'h0,
    EV_FIFO_WR = 3'h1,
    EV_FIFO_POP = 3'h2,
    EV_CMD = 3'h3,
    EV_EE_ARM = 3'h4
  } tsl_ev_t;

  typedef enum logic [9:0] {
    S_MODE = 10'h001,
    S_REG_WR = 10'h002,
    S_REG_RD = 10'h004,
    S_EEW_ADDR = 10'h008,
    S_EEW_DATA = 10'h010,
    S_EER_ADDR = 10'h020,
    S_EER_DATA = 10'h040,
    S_FIFO_WR = 10'h080,
    S_FIFO_RD = 10'h100,
    S_DISCARD = 10'h200
  } tsl_state_t;

  // View of an EEPROM word for both serial and contactless reads; out-of-range words read as zero.
  function automatic logic [31:0] tsl_word_view(input logic [6:0] a, input logic [31:0] mem_word,
                                                input logic [31:0] cfg, input logic [31:0] wl,
                                                input logic [31:0] rl);
    if (a > EE_LAST_WORD) begin
      tsl_word_view = 32'h0000_0000;
    end else if (a == EE_WORD_CFG) begin
      tsl_word_view = cfg;
    end else if (a == EE_WORD_WLOCK) begin
      tsl_word_view = wl;
    end else if (a == EE_WORD_RLOCK) begin
      tsl_word_view = rl;
    end else begin
      tsl_word_view = mem_word;
    end
  endfunction
endpackage

// >>> test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk, rst_n, irq_req, serial_side_supply, rf_wr_req, rf_rd_req, den;
  logic sclk, ss_n, mosi, miso_o, miso_oe, miso_pd_en, irq, fifo_push, fifo_pop, cmd_valid;
  logic rf_wr_ack, rf_wr_denied, rf_rd_valid, rf_rd_denied, pe, ae;
  logic [6:0] rf_wr_addr, rf_rd_addr;
  logic [31:0] rf_wr_data, rf_rd_data, cfg_word, d;
  logic [7:0] fifo_wdata, last_push;
  logic [5:0] cmd_code, last_cmd;
  logic [47:0] r;
  int fails = 0, n_tests = 0, n_cmd = 0, n_push = 0, n_pop = 0;
  tsl_spi_port dut_u (.clk(clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe), .miso_pd_en(miso_pd_en), .irq(irq), .irq_req(irq_req),
    .serial_side_supply(serial_side_supply), .fifo_push(fifo_push), .fifo_wdata(fifo_wdata),
    .fifo_pop(fifo_pop), .fifo_head(8'h5a), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rf_wr_req(rf_wr_req), .rf_wr_addr(rf_wr_addr), .rf_wr_data(rf_wr_data), .rf_wr_ack(rf_wr_ack),
    .rf_wr_denied(rf_wr_denied), .rf_rd_req(rf_rd_req), .rf_rd_addr(rf_rd_addr), .rf_rd_valid(rf_rd_valid),
    .rf_rd_data(rf_rd_data), .rf_rd_denied(rf_rd_denied), .cfg_word(cfg_word), .powerup_event_enable(pe),
    .active_entry_event_enable(ae));
  tsl_master_model m_u (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
    .miso_pd_en(miso_pd_en));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----------------------------------------
  // Event capture in the system domain
  // ----------------------------------------
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_code;
    end
    if (fifo_push === 1'b1) begin
      n_push++;
      last_push = fifo_wdata;
    end
    if (fifo_pop === 1'b1) n_pop++;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic give_up(input string m);
    fails++;
    $display("unexpected at %0t: no answer to %s", $time, m);
    wrap_up();
  endtask
  task automatic ee_wr(input logic [6:0] w, input logic [31:0] v);
    m_u.frame({8'h40, w, 1'b0, v}, 48, r);
  endtask
  task automatic ee_rd(input logic [6:0] w, output logic [31:0] v);
    m_u.frame({8'h7f, w, 1'b0, 32'h0}, 48, r);
    v = r[31:0];
  endtask
  task automatic rf_rd(input logic [6:0] a, output logic dn, output logic [31:0] dt);
    int i;
    @(negedge clk);
    rf_rd_addr = a;
    rf_rd_req = 1'b1;
    @(negedge clk) rf_rd_req = 1'b0;
    for (i = 0; i < 8 && rf_rd_valid !== 1'b1; i++) @(negedge clk);
    if (i == 8) give_up("word read");
    dn = rf_rd_denied;
    dt = rf_rd_data;
  endtask
  task automatic rf_wr(input logic [6:0] a, input logic [31:0] v, output logic dn);
    int i;
    @(negedge clk);
    rf_wr_addr = a;
    rf_wr_data = v;
    rf_wr_req = 1'b1;
    for (i = 0; i < 8 && rf_wr_ack !== 1'b1; i++) @(negedge clk);
    if (i == 8) give_up("word write");
    dn = rf_wr_denied;
    rf_wr_req = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    #3000000;
    give_up("watchdog");
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, irq_req, serial_side_supply, rf_wr_req, rf_rd_req} = 5'h00;
    rf_wr_addr = '0;
    rf_rd_addr = '0;
    rf_wr_data = '0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk({cfg_word, pe, ae}, {32'h2600_0000, 2'h0}, "cfg reset");
    irq_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq, 1'b1, "irq");
    m_u.frame({8'h00, 8'h03}, 16, r);
    chk(miso_pd_en, 1'b1, "pull-down");
    m_u.frame({8'h00, 4'h0}, 12, r);
    m_u.frame({8'h3f, 16'h0}, 24, r);
    chk(r[15:0], 16'h0003, "wrapped read");
    $display("test registers done");
    m_u.frame({8'hc5}, 8, r);
    chk({n_cmd, last_cmd}, {32'd1, 6'h05}, "command");
    m_u.frame({8'h80, 8'ha5, 8'h3c}, 24, r);
    chk({n_push, last_push}, {32'd2, 8'h3c}, "fifo load");
    m_u.frame({8'hbf, 8'h00, 4'h0}, 20, r);
    chk({n_pop, r[11:0]}, {32'd2, 12'h5a5}, "fifo read");
    serial_side_supply = 1'b1;
    repeat (5) @(negedge clk);
    m_u.frame({8'hc5}, 8, r);
    m_u.frame({8'h80, 8'h11}, 16, r);
    m_u.frame({8'h20, 8'h00}, 16, r);
    chk({n_cmd[7:0], n_push[7:0], r[7:0]}, {8'd1, 8'd2, 8'h03}, "reduced supply");
    serial_side_supply = 1'b0;
    $display("test events done");
    ee_wr(7'h05, 32'h1234_5678);
    ee_rd(7'h05, d);
    chk(d, 32'h1234_5678, "word 5");
    ee_rd(7'h20, d);
    chk(d, 32'h0, "word 20h");
    ee_wr(7'h04, 32'h0000_0024);
    rf_rd(7'h05, den, d);
    chk(den, 1'b1, "locked read");
    ee_rd(7'h05, d);
    chk(d, 32'h1234_5678, "serial read of locked word");
    rf_rd(7'h02, den, d);
    chk({den, d}, {1'b0, 32'h2600_0000}, "low word read");
    rf_rd(7'h20, den, d);
    chk(den, 1'b1, "out of range read");
    $display("test read locks done");
    rf_wr(7'h06, 32'hcafe_0001, den);
    ee_rd(7'h06, d);
    chk({den, d}, {1'b0, 32'hcafe_0001}, "open word write");
    ee_wr(7'h03, 32'h0000_0020);
    ee_wr(7'h05, 32'hffff_ffff);
    rf_wr(7'h05, 32'h0, den);
    ee_rd(7'h05, d);
    chk({den, d}, {1'b1, 32'h1234_5678}, "locked word");
    ee_wr(7'h03, 32'h0);
    ee_rd(7'h03, d);
    chk(d, 32'h0000_0020, "lock clear");
    ee_wr(7'h03, 32'h0000_0004);
    ee_wr(7'h03, 32'h0000_0040);
    ee_rd(7'h03, d);
    chk(d, 32'h0000_0024, "frozen lock word");
    rf_wr(7'h00, 32'h0, den);
    chk(den, 1'b1, "word 0 write");
    $display("test write locks done");
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> test/tsl_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_master_model (
  output logic sclk, // Serial clock, idle low.
  output logic ss_n, // Select, active low.
  output logic mosi, // Data to the device.
  input wire logic miso_o, // Data from the device.
  input wire logic miso_oe, // Device drives data.
  input wire logic miso_pd_en // Pull-down switched on.
);
  logic last;
  logic miso_line;
  // A floating line must not show a stale bit, so it toggles unless pulled down.
  assign miso_line = miso_oe ? miso_o : (miso_pd_en ? 1'b0 : ~last);
  always @(posedge sclk) last <= miso_line;
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
  end
  task automatic frame(input logic [47:0] tx, input int nb, output logic [47:0] rx);
    int i;
    rx = '0;
    ss_n = 1'b0;
    #120;
    for (i = nb - 1; i >= 0; i--) begin
      #40 mosi = tx[i];
      #40 sclk = 1'b1;
      #79 rx = {rx[46:0], miso_line};
      #1 sclk = 1'b0;
    end
    #80 ss_n = 1'b1;
    mosi = ~mosi;
    #600;
  endtask
endmodule
`default_nettype wire

// >>> test/tsl_spi_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tsl_spi_port_checker (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Synchronous reset.
  input wire logic ss_n, // Serial select.
  input wire logic miso_oe, // Data out enable.
  input wire logic miso_pd_en, // Pull-down switch.
  input wire logic irq, // Attention request.
  input wire logic irq_req, // Attention source.
  input wire logic serial_side_supply, // Reduced supply flag.
  input wire logic fifo_pop, // FIFO consume strobe.
  input wire logic cmd_valid, // Command strobe.
  input wire logic rf_wr_req, // Word write request.
  input wire logic [6:0] rf_wr_addr, // Word write address.
  input wire logic rf_wr_ack, // Write acknowledge.
  input wire logic rf_wr_denied, // Write refused.
  input wire logic rf_rd_req, // Word read strobe.
  input wire logic [6:0] rf_rd_addr, // Word read address.
  input wire logic rf_rd_valid, // Read answer strobe.
  input wire logic rf_rd_denied, // Read refused.
  input wire logic [31:0] rf_rd_data // Read word.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_ok;
    rf_rd_valid && !rf_rd_denied;
  endsequence
  sequence s_rd_refused;
    rf_rd_valid && rf_rd_denied && rf_rd_data == 32'h0000_0000;
  endsequence
  sequence s_wr_refused;
    rf_wr_ack && rf_wr_denied;
  endsequence
  AST_OE_IDLE: assert property (ss_n && $past(ss_n) |-> !miso_oe)
    else $error("data out driven while deselected");
  AST_PD_RELEASED: assert property (miso_pd_en |-> !miso_oe)
    else $error("pull-down on while driving");
  AST_IRQ_FOLLOW: assert property ($past(rst_n) |-> irq == $past(irq_req))
    else $error("attention output does not follow its source");
  AST_SUPPLY_QUIET: assert property (serial_side_supply && $past(serial_side_supply, 4) |-> !cmd_valid && !fifo_pop)
    else $error("event issued on reduced supply");
  AST_RD_LOW_WORDS: assert property (rf_rd_req && rf_rd_addr < 7'h05 |-> ##2 s_rd_ok)
    else $error("low word read refused");
  AST_RD_OUT_RANGE: assert property (rf_rd_req && rf_rd_addr > 7'h1f |-> ##2 s_rd_refused)
    else $error("out of range read not refused");
  AST_WR_WORD0: assert property ($rose(rf_wr_req) && rf_wr_addr == 7'h00 |-> ##[1:3] s_wr_refused)
    else $error("write to word 0 not refused");
  AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("command strobe longer than one cycle");
  AST_POP_PULSE: assert property (fifo_pop |=> !fifo_pop)
    else $error("pop strobe longer than one cycle");
endmodule
bind tsl_spi_port tsl_spi_port_checker chk_u (.clk(clk), .rst_n(rst_n), .ss_n(ss_n), .miso_oe(miso_oe),
  .miso_pd_en(miso_pd_en), .irq(irq), .irq_req(irq_req), .serial_side_supply(serial_side_supply),
  .fifo_pop(fifo_pop), .cmd_valid(cmd_valid), .rf_wr_req(rf_wr_req), .rf_wr_addr(rf_wr_addr),
  .rf_wr_ack(rf_wr_ack), .rf_wr_denied(rf_wr_denied), .rf_rd_req(rf_rd_req), .rf_rd_addr(rf_rd_addr),
  .rf_rd_valid(rf_rd_valid), .rf_rd_denied(rf_rd_denied), .rf_rd_data(rf_rd_data));
`default_nettype wire
